// file: verilog/ssa_analyzer.sv
// two sliding-window 4096-point radix-2 transform engines
// assumes sample strobes come from logic on clock_in and that the
// consumer of the result stream never stalls
// and that the interval parameters stay below the pending ceiling
`timescale 1ns/1ps

module ssa_analyzer #(
  parameter int FIRST_INTERVAL = ssa_pkg::DEFAULT_INTERVAL,
  parameter int SECOND_INTERVAL = ssa_pkg::DEFAULT_INTERVAL
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [ssa_pkg::SAMPLE_W-1:0] first_sample_in,
  input wire logic first_sample_valid_in,
  input wire logic [ssa_pkg::SAMPLE_W-1:0] second_sample_in,
  input wire logic second_sample_valid_in,
  output logic first_result_valid_out,
  output logic first_result_first_out,
  output logic [ssa_pkg::DATA_W-1:0] first_result_re_out,
  output logic [ssa_pkg::DATA_W-1:0] first_result_im_out,
  output logic second_result_valid_out,
  output logic second_result_first_out,
  output logic [ssa_pkg::DATA_W-1:0] second_result_re_out,
  output logic [ssa_pkg::DATA_W-1:0] second_result_im_out
);

  ////////////////////////////////////////////////////////////////////////////
  // twiddle table, shared: each engine reads its own entry per cycle

  logic signed [ssa_pkg::TW_W-1:0] cos_rom [0:ssa_pkg::HALF_POINTS-1];
  logic signed [ssa_pkg::TW_W-1:0] sin_rom [0:ssa_pkg::HALF_POINTS-1];

  // rom built at elaboration; rounding to nearest keeps twiddle error
  // symmetric, which the 24-bit path absorbs
  initial begin
    for (int k = 0; k < ssa_pkg::HALF_POINTS; k++) begin
      cos_rom[k] = ssa_pkg::TW_W'($rtoi($floor(ssa_pkg::TW_SCALE *
                   $cos(6.283185307179586 * k / ssa_pkg::POINTS) + 0.5)));
      sin_rom[k] = ssa_pkg::TW_W'($rtoi($floor(ssa_pkg::TW_SCALE *
                   $sin(6.283185307179586 * k / ssa_pkg::POINTS) + 0.5)));
    end
  end

  function automatic logic [11:0] bit_reverse(input logic [11:0] v);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 0; i < ssa_pkg::LOG2_POINTS; i++) begin
      r[i] = v[ssa_pkg::LOG2_POINTS-1-i];
    end
    return r;
  endfunction : bit_reverse

  ////////////////////////////////////////////////////////////////////////////
  // per-engine port mapping

  logic [ssa_pkg::SAMPLE_W-1:0] smp [0:ssa_pkg::ENGINES-1];
  logic smp_valid [0:ssa_pkg::ENGINES-1];
  ssa_pkg::ssa_engine_t eng_reg [0:ssa_pkg::ENGINES-1];

  assign smp[0] = first_sample_in;
  assign smp[1] = second_sample_in;
  assign smp_valid[0] = first_sample_valid_in;
  assign smp_valid[1] = second_sample_valid_in;

  assign first_result_valid_out = eng_reg[0].out_valid;
  assign first_result_first_out = eng_reg[0].out_first;
  assign first_result_re_out = eng_reg[0].out_re;
  assign first_result_im_out = eng_reg[0].out_im;
  assign second_result_valid_out = eng_reg[1].out_valid;
  assign second_result_first_out = eng_reg[1].out_first;
  assign second_result_re_out = eng_reg[1].out_re;
  assign second_result_im_out = eng_reg[1].out_im;

  ////////////////////////////////////////////////////////////////////////////
  // engines: own history, work memory and control, no shared state

  for (genvar g = 0; g < ssa_pkg::ENGINES; g++) begin : g_engine
    localparam logic [12:0] INTERVAL = 13'((g == 0) ? FIRST_INTERVAL : SECOND_INTERVAL);

    logic [ssa_pkg::SAMPLE_W-1:0] hist [0:ssa_pkg::POINTS-1];
    logic signed [ssa_pkg::DATA_W-1:0] work_re [0:ssa_pkg::POINTS-1];
    logic signed [ssa_pkg::DATA_W-1:0] work_im [0:ssa_pkg::POINTS-1];
    ssa_pkg::ssa_engine_t eng_next;
    logic [11:0] mask;
    logic [11:0] half;
    logic [11:0] addr_a;
    logic [11:0] addr_b;
    logic [10:0] tw_idx;
    logic [11:0] load_addr;
    logic signed [ssa_pkg::DATA_W-1:0] load_val;
    logic signed [41:0] t_re;
    logic signed [41:0] t_im;
    logic signed [ssa_pkg::DATA_W-1:0] a_re_new;
    logic signed [ssa_pkg::DATA_W-1:0] a_im_new;
    logic signed [ssa_pkg::DATA_W-1:0] b_re_new;
    logic signed [ssa_pkg::DATA_W-1:0] b_im_new;
    logic [12:0] pending_inc;

    // butterfly addressing and arithmetic, one butterfly per cycle
    always_comb begin
      half = 12'h001 << eng_reg[g].stage;
      mask = half - 12'h001;
      addr_a = 12'(((eng_reg[g].idx & ~mask) << 1) | (eng_reg[g].idx & mask));
      addr_b = addr_a | half;
      tw_idx = 11'((eng_reg[g].idx & mask) << (ssa_pkg::LOG2_POINTS - 1 - eng_reg[g].stage));
      // oldest sample sits at base, so base + n walks the window in age order
      load_addr = eng_reg[g].base + eng_reg[g].idx;
      load_val = ssa_pkg::DATA_W'($signed(hist[load_addr]));
      // b * exp(-j*2*pi*k/N)
      t_re = (42'(work_re[addr_b]) * 42'(cos_rom[tw_idx]) +
              42'(work_im[addr_b]) * 42'(sin_rom[tw_idx])) >>> ssa_pkg::TW_SHIFT;
      t_im = (42'(work_im[addr_b]) * 42'(cos_rom[tw_idx]) -
              42'(work_re[addr_b]) * 42'(sin_rom[tw_idx])) >>> ssa_pkg::TW_SHIFT;
      // halving every stage keeps 16-bit input inside 24 bits over 12 stages
      a_re_new = ssa_pkg::DATA_W'((42'(work_re[addr_a]) + t_re) >>> 1);
      a_im_new = ssa_pkg::DATA_W'((42'(work_im[addr_a]) + t_im) >>> 1);
      b_re_new = ssa_pkg::DATA_W'((42'(work_re[addr_a]) - t_re) >>> 1);
      b_im_new = ssa_pkg::DATA_W'((42'(work_im[addr_a]) - t_im) >>> 1);
    end

    // control next state
    always_comb begin
      eng_next = eng_reg[g];
      // result strobes last one cycle unless DUMP raises them again
      eng_next.out_valid = 1'b0;
      eng_next.out_first = 1'b0;
      pending_inc = eng_reg[g].pending;
      // sample intake runs in every state so nothing is dropped mid-transform
      if (smp_valid[g]) begin
        eng_next.wr_ptr = eng_reg[g].wr_ptr + 12'h001;
        if (eng_reg[g].wr_ptr == ssa_pkg::LAST_POINT) begin
          eng_next.filled = 1'b1;
        end
        if (eng_reg[g].pending != ssa_pkg::PENDING_MAX) begin
          pending_inc = eng_reg[g].pending + 13'h0001;
        end
      end
      // the fill is not a backlog: one interval is held ready so the first
      // start follows the fill and each later one waits a full interval
      if (!eng_reg[g].filled) begin
        pending_inc = INTERVAL;
      end
      eng_next.pending = pending_inc;
      case (eng_reg[g].state)
        ssa_pkg::SSA_IDLE: begin
          // no start until the window holds real samples; a backlog starts at once
          if (eng_reg[g].filled && pending_inc >= INTERVAL) begin
            eng_next.state = ssa_pkg::SSA_LOAD;
            eng_next.pending = pending_inc - INTERVAL;
            eng_next.base = eng_next.wr_ptr;
            eng_next.idx = 12'h000;
          end
        end
        ssa_pkg::SSA_LOAD: begin
          eng_next.idx = eng_reg[g].idx + 12'h001;
          if (eng_reg[g].idx == ssa_pkg::LAST_POINT) begin
            eng_next.state = ssa_pkg::SSA_CALC;
            eng_next.idx = 12'h000;
            eng_next.stage = 4'h0;
          end
        end
        ssa_pkg::SSA_CALC: begin
          // about 33k cycles total, well inside the 0.6 ms budget
          eng_next.idx = eng_reg[g].idx + 12'h001;
          if (eng_reg[g].idx == ssa_pkg::LAST_BUTTERFLY) begin
            eng_next.idx = 12'h000;
            if (eng_reg[g].stage == ssa_pkg::LAST_STAGE) begin
              eng_next.state = ssa_pkg::SSA_DUMP;
            end else begin
              eng_next.stage = eng_reg[g].stage + 4'h1;
            end
          end
        end
        ssa_pkg::SSA_DUMP: begin
          // no back-pressure: the consumer must take a point every cycle or
          // lose it, which keeps the dump at exactly 4096 cycles
          // bit-reversed load makes work memory bin-ordered here
          eng_next.out_valid = 1'b1;
          eng_next.out_first = (eng_reg[g].idx == 12'h000);
          eng_next.out_re = work_re[eng_reg[g].idx];
          eng_next.out_im = work_im[eng_reg[g].idx];
          eng_next.idx = eng_reg[g].idx + 12'h001;
          if (eng_reg[g].idx == ssa_pkg::LAST_POINT) begin
            eng_next.state = ssa_pkg::SSA_IDLE;
            eng_next.idx = 12'h000;
          end
        end
        default: begin
          eng_next = ssa_pkg::ENGINE_RESET;
        end
      endcase
    end

    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        eng_reg[g] <= ssa_pkg::ENGINE_RESET;
      end else begin
        eng_reg[g] <= eng_next;
      end
    end

    // memories carry no reset; the filled flag hides stale history
    // a sample landing during LOAD only hits slots already read, so the
    // window survives input at up to one sample per cycle
    always_ff @(posedge clock_in) begin
      if (!rst_in && smp_valid[g]) begin
        hist[eng_reg[g].wr_ptr] <= smp[g];
      end
      if (eng_reg[g].state == ssa_pkg::SSA_LOAD) begin
        work_re[bit_reverse(eng_reg[g].idx)] <= load_val;
        work_im[bit_reverse(eng_reg[g].idx)] <= '0;
      end else if (eng_reg[g].state == ssa_pkg::SSA_CALC) begin
        work_re[addr_a] <= a_re_new;
        work_im[addr_a] <= a_im_new;
        work_re[addr_b] <= b_re_new;
        work_im[addr_b] <= b_im_new;
      end
    end
  end

endmodule : ssa_analyzer

// file: verilog/ssa_pkg.sv
// constants and types shared by the sliding spectrum analyzer
// assumes one 100 MHz clock and a synchronous active-high reset
// Summary of operation
// - two independent 4096-point spectrum engines
// - transform covers the latest 4096 samples
// - start interval is a per-engine parameter
// - default interval is 64 new samples
// - each transform including readout within 0.6 ms
// - both engines run concurrently
// - 4096 complex points, real and imaginary
package ssa_pkg;

  localparam int POINTS = 4096;
  localparam int LOG2_POINTS = 12;
  localparam int HALF_POINTS = 2048;
  localparam int SAMPLE_W = 16;
  localparam int DATA_W = 24;
  localparam int TW_W = 16;
  localparam int TW_SCALE = 32767;
  localparam int TW_SHIFT = 15;
  localparam int ENGINES = 2;
  localparam int DEFAULT_INTERVAL = 64;
  localparam int SAMPLE_RATE_HZ = 16000;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int TRANSFORM_TIME_US = 600;
  localparam int TRANSFORM_MAX_CYCLES = TRANSFORM_TIME_US * 1000 / CLOCK_PERIOD_NS;
  localparam logic [11:0] LAST_POINT = 12'hfff;
  localparam logic [11:0] LAST_BUTTERFLY = 12'h7ff;
  localparam logic [3:0] LAST_STAGE = 4'hb;
  localparam logic [12:0] PENDING_MAX = 13'h1fff;
  localparam logic [11:0] RESET_PTR = 12'h000;

  typedef enum logic [3:0] {
    SSA_IDLE = 4'h1,
    SSA_LOAD = 4'h2,
    SSA_CALC = 4'h4,
    SSA_DUMP = 4'h8
  } ssa_state_t;

  typedef struct packed {
    ssa_state_t state;
    logic [11:0] idx;
    logic [3:0] stage;
    logic [11:0] base;
    logic [11:0] wr_ptr;
    logic [12:0] pending;
    logic filled;
    logic out_valid;
    logic out_first;
    logic [DATA_W-1:0] out_re;
    logic [DATA_W-1:0] out_im;
  } ssa_engine_t;

  localparam ssa_engine_t ENGINE_RESET = '{
    state: SSA_IDLE, idx: 12'h000, stage: 4'h0, base: 12'h000, wr_ptr: RESET_PTR,
    pending: 13'h0000, filled: 1'b0, out_valid: 1'b0, out_first: 1'b0,
    out_re: 24'h000000, out_im: 24'h000000};

endpackage : ssa_pkg

// file: verif/ssa_analyzer_sva.sv
// result framing checks for both engines
// assumes a bind onto ssa_analyzer, one clock, synchronous reset
`timescale 1ns/1ps
module ssa_analyzer_sva (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic first_result_valid_out,
  input wire logic first_result_first_out,
  input wire logic second_result_valid_out,
  input wire logic second_result_first_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // valid cycles seen so far in the running burst
  logic [12:0] run1_reg;
  logic [12:0] run2_reg;
  always_ff @(posedge clock_in) begin
    run1_reg <= (rst_in || !first_result_valid_out) ? 13'h0000 : run1_reg + 13'h0001;
    run2_reg <= (rst_in || !second_result_valid_out) ? 13'h0000 : run2_reg + 13'h0001;
  end
  ////////////////////////////////////////////////////////////////
  a_first_opens_one: assert property (first_result_first_out |->
    first_result_valid_out && run1_reg == 13'h0000) else $error("marker off bin 0");
  a_zero_marked_one: assert property (first_result_valid_out && run1_reg == 13'h0000
    |-> first_result_first_out) else $error("bin 0 without marker");
  a_burst_len_one: assert property (!first_result_valid_out && run1_reg != 13'h0000
    |-> run1_reg == 13'h1000) else $error("burst length wrong");
  a_quiet_start_one: assert property ($fell(rst_in) |->
    (!first_result_valid_out) [*8]) else $error("output before window full");
  a_first_opens_two: assert property (second_result_first_out |->
    second_result_valid_out && run2_reg == 13'h0000) else $error("marker off bin 0");
  a_zero_marked_two: assert property (second_result_valid_out && run2_reg == 13'h0000
    |-> second_result_first_out) else $error("bin 0 without marker");
  a_burst_len_two: assert property (!second_result_valid_out && run2_reg != 13'h0000
    |-> run2_reg == 13'h1000) else $error("burst length wrong");
  a_quiet_start_two: assert property ($fell(rst_in) |->
    (!second_result_valid_out) [*8]) else $error("output before window full");
  c_burst_one: cover property ($rose(first_result_first_out));
  c_burst_two: cover property ($rose(second_result_first_out));
  c_burst_end: cover property (!first_result_valid_out && run1_reg == 13'h1000);
endmodule : ssa_analyzer_sva

// file: verif/ssa_source.sv
// sample source model: a run of evenly spaced sample strobes
// assumes go, count, gap and value come from the bench on clock_in
`timescale 1ns/1ps
module ssa_source (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [12:0] count_in,
  input wire logic [7:0] gap_in,
  input wire logic [ssa_pkg::SAMPLE_W-1:0] value_in,
  output logic [ssa_pkg::SAMPLE_W-1:0] sample_out,
  output logic valid_out,
  output logic busy_out
);
  logic [12:0] left_reg;
  logic [7:0] wait_reg;
  logic [ssa_pkg::SAMPLE_W-1:0] val_reg;
  assign busy_out = left_reg != 13'h0000;
  always_ff @(posedge clock_in) begin
    valid_out <= 1'b0;
    // data flips off the strobe so a stale value is never trusted
    sample_out <= ~sample_out;
    if (rst_in) begin
      left_reg <= 13'h0000;
      wait_reg <= 8'h00;
      sample_out <= 16'h0000;
    end else if (go_in) begin
      left_reg <= count_in;
      wait_reg <= 8'h00;
      val_reg <= value_in;
    end else if (busy_out && wait_reg == 8'h00) begin
      valid_out <= 1'b1;
      sample_out <= val_reg;
      left_reg <= left_reg - 13'h0001;
      wait_reg <= gap_in;
    end else if (wait_reg != 8'h00) begin
      wait_reg <= wait_reg - 8'h01;
    end
  end
endmodule : ssa_source

// file: verif/sliding_spectrum_analyzer_bench.sv
// bench: fill both windows, slide both by 64 samples, check spectra of constant input
// assumes ssa_pkg, ssa_analyzer, ssa_source and the checker compiled first
`timescale 1ns/1ps
module sliding_spectrum_analyzer_bench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic go_in = 1'b0;
  logic [12:0] count_in = 13'h0000;
  logic [7:0] gap_in = 8'h00;
  logic [15:0] value_in = 16'h0000;
  logic [15:0] s1, s2;
  logic v1, v2, b1, b2, r1v, r1f, r2v, r2f;
  logic [23:0] r1re, r1im, r2re, r2im;
  time t_start;
  int mismatches = 0;
  int checks = 0;
  ssa_source src1_inst (.clock_in(clock_in), .rst_in(rst_in), .go_in(go_in),
    .count_in(count_in), .gap_in(gap_in), .value_in(value_in), .sample_out(s1),
    .valid_out(v1), .busy_out(b1));
  // second engine sees half the value, so the two spectra differ
  ssa_source src2_inst (.clock_in(clock_in), .rst_in(rst_in), .go_in(go_in),
    .count_in(count_in), .gap_in(gap_in), .value_in({value_in[15], value_in[15:1]}),
    .sample_out(s2), .valid_out(v2), .busy_out(b2));
  ssa_analyzer #(.FIRST_INTERVAL(64), .SECOND_INTERVAL(65)) ssa_analyzer_inst (
    .clock_in(clock_in), .rst_in(rst_in), .first_sample_in(s1),
    .first_sample_valid_in(v1), .second_sample_in(s2), .second_sample_valid_in(v2),
    .first_result_valid_out(r1v), .first_result_first_out(r1f),
    .first_result_re_out(r1re), .first_result_im_out(r1im),
    .second_result_valid_out(r2v), .second_result_first_out(r2f),
    .second_result_re_out(r2re), .second_result_im_out(r2im));
  initial forever #5 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_bit
  // twiddles of 32767 lose a little each stage, so allow a small margin
  task automatic check_near(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if ($isunknown(got) || $signed(got - exp) > 16 || $signed(got - exp) < -16) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_near
  task automatic feed(input logic [12:0] n, input logic [7:0] gap, input logic [15:0] val);
    @(posedge clock_in);
    go_in <= 1'b1;
    count_in <= n;
    gap_in <= gap;
    value_in <= val;
    @(posedge clock_in);
    go_in <= 1'b0;
  endtask : feed
  task automatic wait_idle(input int bound);
    int n;
    // look only after an edge, so a go taken at this same edge has landed
    for (n = 0; n < bound; n++) begin
      @(posedge clock_in);
      if (b1 === 1'b0) break;
    end
    if (n == bound) begin
      mismatches++;
      test_done();
    end
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////
  task automatic fill_window();
    feed(13'h1000, 8'h00, 16'h4000);
    wait_idle(5000);
    t_start = $time;
    check_bit(r1v, 1'b0);
  endtask : fill_window
  task automatic slide_during_transform();
    repeat (5000) @(posedge clock_in);
    feed(13'h0040, 8'h63, 16'hc000);
    wait_idle(8000);
    check_bit(r1v | r2v, 1'b0);
  endtask : slide_during_transform
  task automatic check_burst(input logic [23:0] exp1, input logic [23:0] exp2,
                             input logic flat);
    int n;
    for (n = 0; n < 70000 && r1f !== 1'b1; n++) @(posedge clock_in);
    if (n == 70000) begin
      mismatches++;
      test_done();
    end
    // takes every point, one per cycle, as the transfer logic must
    for (n = 0; n < 4096; n++) begin
      check_bit(r1v, 1'b1);
      check_bit(r2v, flat);
      if (n == 0 || flat) check_near(r1re, (n == 0) ? exp1 : 24'h000000);
      if (flat) check_near(r1im, 24'h000000);
      if (flat) check_near(r2re, (n == 0) ? exp2 : 24'h000000);
      if (flat) check_near(r2im, 24'h000000);
      @(posedge clock_in);
    end
    check_bit(r1v | r2v, 1'b0);
    if (flat) check_bit(($time - t_start) < 64'd600000, 1'b1);
  endtask : check_burst
  initial begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    fill_window();
    slide_during_transform();
    check_burst(24'h004000, 24'h002000, 1'b1);
    // 4032 old plus 64 negated samples; the 65-sample engine must stay quiet
    check_burst(24'h003e00, 24'h000000, 1'b0);
    test_done();
  end
endmodule : sliding_spectrum_analyzer_bench
bind ssa_analyzer ssa_analyzer_sva ssa_analyzer_sva_inst (.clock_in(clock_in),
  .rst_in(rst_in), .first_result_valid_out(first_result_valid_out),
  .first_result_first_out(first_result_first_out),
  .second_result_valid_out(second_result_valid_out),
  .second_result_first_out(second_result_first_out));
